// ### inc/hwm_map.svh
/*
  register offsets, field positions, reset values and timing counts of the
  monitor pin logic. assumes inclusion by bare name from the design files.
*/
`ifndef HWM_MAP_SVH
`define HWM_MAP_SVH

// clock, timed pulses and fan window
`define HWM_CLK_HZ 40000000
`define HWM_PULSE_MS 20
`define HWM_PULSE_CYC ((`HWM_PULSE_MS * `HWM_CLK_HZ + 999) / 1000)
`define HWM_FAN_WINDOW 4096

// register offsets
`define HWM_BOOT_DATA 8'h08
`define HWM_BOOT_PTR 8'h09
`define HWM_VALUE_BASE 4'h2
`define HWM_LIMIT_BASE 4'h3
`define HWM_CFG 8'h40
`define HWM_STAT1 8'h41
`define HWM_STAT2 8'h42
`define HWM_HMASK1 8'h43
`define HWM_HMASK2 8'h44
`define HWM_MMASK1 8'h45
`define HWM_MMASK2 8'h46

// field positions
`define HWM_CFG_MGMT_EN 1
`define HWM_CFG_HOST_EN 2
`define HWM_CFG_PWR_ON 3
`define HWM_CFG_NMI_MODE 5
`define HWM_CFG_RST_GO 7
`define HWM_ST2_INTR 4
`define HWM_ST2_CHAIN 6
`define HWM_MM2_CHAIN 6
`define HWM_MM2_RST_EN 7
`define HWM_HM2_INTR_CLR 7

// reset values
`define HWM_CFG_RST 8'h00
`define HWM_MASK_RST 8'hFF
`define HWM_LIMIT_RST 8'hFF

`endif

// ### inc/hwm_pkg.sv
/*
  types shared by the monitor pin logic.
  assumes nothing beyond a SystemVerilog compiler.
*/
package hwm_pkg;
  typedef enum logic [0:0] {
    HWM_IDLE = 1'b0,
    HWM_RUN = 1'b1
  } hwm_tmr_state_t;
  typedef logic [7:0] hwm_byte_t;
endpackage

// ### inc/hwm_pulse_if.sv
/*
  handshake between the pin logic and one timed pulse generator.
  assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface hwm_pulse_if;
  logic start;
  logic active;
  logic done;
  modport ctrl (output start, input active, input done);
  modport timer (input start, output active, output done);
endinterface
`default_nettype wire

// ### design/hwm_pulse_timer.sv
/*
  timed pulse generator: holds active for a fixed count of clock cycles.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module hwm_pulse_timer #(
  parameter int unsigned CYCLES = 800000
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // control
  hwm_pulse_if.timer pulse
);
  hwm_pkg::hwm_tmr_state_t state;
  hwm_pkg::hwm_tmr_state_t next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic last_w;

  // pure count of edges, so any clock rate down to a crawl is fine (see RL7)
  assign last_w = (cnt == CYCLES - 32'h0000_0001);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      hwm_pkg::HWM_IDLE: begin
        // a start while running is ignored, the pulse is not stretched
        if (pulse.start) begin
          next_state = hwm_pkg::HWM_RUN;
          next_cnt = 32'h0000_0000;
        end
      end
      hwm_pkg::HWM_RUN: begin
        if (last_w) begin
          next_state = hwm_pkg::HWM_IDLE;
        end else begin
          next_cnt = cnt + 32'h0000_0001;
        end
      end
      default: next_state = hwm_pkg::HWM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= hwm_pkg::HWM_IDLE;
      cnt <= 32'h0000_0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign pulse.active = (state == hwm_pkg::HWM_RUN);
  assign pulse.done = (state == hwm_pkg::HWM_RUN) && last_w;
endmodule
`default_nettype wire

// ### design/hwm_pin_logic.sv
/*
  pin logic of the hardware monitor: register port, limit alarms, interrupt
  outputs, intrusion latch and clear, master reset, power switch, boot code
  storage, fan tach counting, connectivity test output.
  assumes synchronous inputs, one clock, converted samples from an external ADC.
*/
//
// Function
// RL1 - chained mgmt input passes, gated by mask, enable
// RL2 - intrusion pin high latches an intrusion event
// RL3 - host mask2 bit7 pulls intrusion low 20 ms
// RL4 - master reset pulse 20 ms when enabled
// RL5 - active-low push-pull power switch, software controlled
// RL6 - host strobes reads and writes, 8-bit data
// RL7 - static design, works at any slow clock
// RL8 - connectivity test output is NAND of inputs
// RL9 - 32-byte boot code RAM, auto-increment address
// RL10 - limit compare raises two maskable interrupt outputs
// RL11 - 8-bit conversion results readable any time
// RL12 - three fan tach inputs measure fan speed
// RL13 - host irq enabled by cfg bit2, bit5 mode
// RL14 - mgmt irq enabled by cfg bit1
// RL15 - host selects device and internal port
// RL16 - intrusion held until clear; 20 ms counted
`timescale 1ns/1ps
`default_nettype none
`include "hwm_map.svh"
module hwm_pin_logic #(
  parameter int unsigned PULSE_CYCLES = `HWM_PULSE_CYC,
  parameter int unsigned FAN_WINDOW = `HWM_FAN_WINDOW,
  parameter int unsigned NADC = 7,
  parameter int unsigned NFAN = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // converter samples
  input wire logic [7:0] adc_data_i,
  input wire logic [2:0] adc_chan_i,
  input wire logic adc_valid_i,
  // fan tach
  input wire logic [NFAN-1:0] fan_tach_i,
  // chained management interrupt, active low
  input wire logic chained_mgmt_irq_in_n_i,
  // management interrupt, open drain, active low
  output logic mgmt_irq_out_o,
  output logic mgmt_irq_out_oe_o,
  // host interrupt, open source or open drain
  output logic host_irq_o,
  output logic host_irq_oe_o,
  // chassis intrusion, two-way, open drain
  input wire logic intrusion_i,
  output logic intrusion_o,
  output logic intrusion_oe_o,
  // master reset, open drain, active low
  output logic master_rst_n_o,
  output logic master_rst_oe_o,
  // power switch, push-pull, active low
  output logic power_sw_n_o,
  // connectivity test
  output logic connectivity_test_out_o
);
  localparam int unsigned NVAL = NADC + NFAN;

  hwm_pulse_if intr_pulse ();
  hwm_pulse_if rst_pulse ();

  // host side strobes are single cycle and never overlap (see RL6)
  hwm_pkg::hwm_byte_t cfg;
  hwm_pkg::hwm_byte_t stat1;
  hwm_pkg::hwm_byte_t stat2_lo;
  hwm_pkg::hwm_byte_t hmask1;
  hwm_pkg::hwm_byte_t hmask2;
  hwm_pkg::hwm_byte_t mmask1;
  hwm_pkg::hwm_byte_t mmask2;
  hwm_pkg::hwm_byte_t value_q [NVAL];
  hwm_pkg::hwm_byte_t limit_q [NVAL];
  hwm_pkg::hwm_byte_t boot_mem [32];
  logic [4:0] boot_ptr;
  logic intr_latched;
  logic [NFAN-1:0] tach_prev;
  logic [7:0] fan_cnt [NFAN];
  logic [31:0] fan_win;
  logic fan_tick;

  // decode
  logic wr_cfg;
  logic wr_hmask1;
  logic wr_hmask2;
  logic wr_mmask1;
  logic wr_mmask2;
  logic wr_boot;
  logic wr_ptr;
  logic rd_boot;
  logic rd_stat1;
  logic rd_stat2;
  logic boot_access;
  logic val_hit;
  logic lim_hit;
  logic [3:0] idx;
  logic [NVAL-1:0] alarm_w;
  logic [7:0] stat2;
  logic [7:0] next_stat1;
  logic [7:0] next_stat2_lo;
  logic host_raw;
  logic mgmt_raw;
  logic chain_active;
  logic [7:0] rd_mux;
  logic [7:0] alarm_hi;
  logic [7:0] alarm_lo;

  assign idx = reg_addr_i[3:0];
  assign val_hit = (reg_addr_i[7:4] == `HWM_VALUE_BASE) && ({28'h000_0000, idx} < NVAL);
  assign lim_hit = (reg_addr_i[7:4] == `HWM_LIMIT_BASE) && ({28'h000_0000, idx} < NVAL);
  assign wr_cfg = reg_wr_i && (reg_addr_i == `HWM_CFG);
  assign wr_hmask1 = reg_wr_i && (reg_addr_i == `HWM_HMASK1);
  assign wr_hmask2 = reg_wr_i && (reg_addr_i == `HWM_HMASK2);
  assign wr_mmask1 = reg_wr_i && (reg_addr_i == `HWM_MMASK1);
  assign wr_mmask2 = reg_wr_i && (reg_addr_i == `HWM_MMASK2);
  assign wr_boot = reg_wr_i && (reg_addr_i == `HWM_BOOT_DATA);
  assign wr_ptr = reg_wr_i && (reg_addr_i == `HWM_BOOT_PTR);
  assign rd_boot = reg_rd_i && (reg_addr_i == `HWM_BOOT_DATA);
  assign rd_stat1 = reg_rd_i && (reg_addr_i == `HWM_STAT1);
  assign rd_stat2 = reg_rd_i && (reg_addr_i == `HWM_STAT2);
  assign boot_access = wr_boot || rd_boot;

  // limit compare per monitored value (see RL10)
  genvar g;
  generate
    for (g = 0; g < NVAL; g = g + 1) begin : g_cmp
      assign alarm_w[g] = value_q[g] > limit_q[g];
    end
  endgenerate
  assign alarm_lo = alarm_w[7:0];
  assign alarm_hi = {{(16 - NVAL){1'b0}}, alarm_w[NVAL-1:8]};

  // alarm status bits are read-to-clear; a new alarm in the same cycle wins
  assign next_stat1 = (rd_stat1 ? 8'h00 : stat1) | alarm_lo;
  assign next_stat2_lo = (rd_stat2 ? 8'h00 : stat2_lo) | alarm_hi;
  assign chain_active = !chained_mgmt_irq_in_n_i;
  assign stat2 = stat2_lo | ({7'h00, intr_latched} << `HWM_ST2_INTR) | ({7'h00, chain_active} << `HWM_ST2_CHAIN);

  // a mask bit of one blocks the source
  assign host_raw = (|(stat1 & ~hmask1)) || (|(stat2_lo & ~hmask2)) || (intr_latched && !hmask2[`HWM_ST2_INTR]); // see RL10
  assign mgmt_raw = (|(stat1 & ~mmask1)) || (|(stat2_lo & ~mmask2))
    || (chain_active && !mmask2[`HWM_MM2_CHAIN]); // see RL1

  // timed pulses
  assign intr_pulse.start = wr_hmask2 && reg_wdata_i[`HWM_HM2_INTR_CLR]; // see RL3
  assign rst_pulse.start = wr_cfg && reg_wdata_i[`HWM_CFG_RST_GO] && mmask2[`HWM_MM2_RST_EN]; // see RL4

  hwm_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_intr_timer (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pulse(intr_pulse)
  );

  hwm_pulse_timer #(
    .CYCLES(PULSE_CYCLES)
  ) u_rst_timer (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .pulse(rst_pulse)
  );

  // read selection
  assign rd_mux = (reg_addr_i == `HWM_CFG) ? cfg :
    (reg_addr_i == `HWM_STAT1) ? stat1 :
    (reg_addr_i == `HWM_STAT2) ? stat2 :
    (reg_addr_i == `HWM_HMASK1) ? hmask1 :
    (reg_addr_i == `HWM_HMASK2) ? hmask2 :
    (reg_addr_i == `HWM_MMASK1) ? mmask1 :
    (reg_addr_i == `HWM_MMASK2) ? mmask2 :
    (reg_addr_i == `HWM_BOOT_DATA) ? boot_mem[boot_ptr] :
    (reg_addr_i == `HWM_BOOT_PTR) ? {3'h0, boot_ptr} :
    val_hit ? value_q[idx] :
    lim_hit ? limit_q[idx] : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00; // see RL6
    end
  end

  // control registers; the reset-go bit is a command and is not stored
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg <= `HWM_CFG_RST;
      hmask1 <= `HWM_MASK_RST;
      hmask2 <= `HWM_MASK_RST;
      mmask1 <= `HWM_MASK_RST;
      mmask2 <= `HWM_MASK_RST;
    end else begin
      if (wr_cfg) cfg <= reg_wdata_i & ~(8'h01 << `HWM_CFG_RST_GO);
      if (wr_hmask1) hmask1 <= reg_wdata_i;
      if (wr_hmask2) hmask2 <= reg_wdata_i;
      if (wr_mmask1) mmask1 <= reg_wdata_i;
      if (wr_mmask2) mmask2 <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stat1 <= 8'h00;
      stat2_lo <= 8'h00;
    end else begin
      stat1 <= next_stat1;
      stat2_lo <= next_stat2_lo;
    end
  end

  // intrusion: set is ignored while the clear pulse is active, so a pin still high re-latches once it ends
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      intr_latched <= 1'b0;
    end else if (intrusion_i && !intr_pulse.active) begin
      intr_latched <= 1'b1; // see RL2
    end else if (intr_pulse.done) begin
      intr_latched <= 1'b0; // see RL16
    end
  end

  // limits
  generate
    for (g = 0; g < NVAL; g = g + 1) begin : g_lim
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          limit_q[g] <= `HWM_LIMIT_RST;
        end else if (reg_wr_i && lim_hit && ({28'h000_0000, idx} == g)) begin
          limit_q[g] <= reg_wdata_i;
        end
      end
    end
  endgenerate

  // converter results, readable at any time (see RL11)
  generate
    for (g = 0; g < NADC; g = g + 1) begin : g_adc
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          value_q[g] <= 8'h00;
        end else if (adc_valid_i && ({29'h0000_0000, adc_chan_i} == g)) begin
          value_q[g] <= adc_data_i;
        end
      end
    end
  endgenerate

  // fan measurement window; counts above 255 saturate
  assign fan_tick = (fan_win == FAN_WINDOW - 32'h0000_0001);

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fan_win <= 32'h0000_0000;
      tach_prev <= '0;
    end else begin
      fan_win <= fan_tick ? 32'h0000_0000 : fan_win + 32'h0000_0001;
      tach_prev <= fan_tach_i;
    end
  end

  generate
    for (g = 0; g < NFAN; g = g + 1) begin : g_fan
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          fan_cnt[g] <= 8'h00;
          value_q[NADC + g] <= 8'h00;
        end else if (fan_tick) begin
          value_q[NADC + g] <= fan_cnt[g]; // see RL12
          fan_cnt[g] <= 8'h00;
        end else if (fan_tach_i[g] && !tach_prev[g] && (fan_cnt[g] != 8'hFF)) begin
          fan_cnt[g] <= fan_cnt[g] + 8'h01;
        end
      end
    end
  endgenerate

  // boot code storage; pointer wraps after the last byte (see RL9)
  always_ff @(posedge core_clk_i) begin
    if (wr_boot) begin
      boot_mem[boot_ptr] <= reg_wdata_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      boot_ptr <= 5'h00;
    end else if (wr_ptr) begin
      boot_ptr <= reg_wdata_i[4:0];
    end else if (boot_access) begin
      boot_ptr <= boot_ptr + 5'h01; // see RL9
    end
  end

  // pin outputs, all registered
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mgmt_irq_out_o <= 1'b0;
      mgmt_irq_out_oe_o <= 1'b0;
      host_irq_o <= 1'b0;
      host_irq_oe_o <= 1'b0;
      intrusion_o <= 1'b0;
      intrusion_oe_o <= 1'b0;
      master_rst_n_o <= 1'b0;
      master_rst_oe_o <= 1'b0;
      power_sw_n_o <= 1'b1;
      connectivity_test_out_o <= 1'b0;
    end else begin
      mgmt_irq_out_oe_o <= mgmt_raw && cfg[`HWM_CFG_MGMT_EN]; // see RL14
      host_irq_o <= cfg[`HWM_CFG_NMI_MODE]; // see RL13
      host_irq_oe_o <= host_raw && cfg[`HWM_CFG_HOST_EN]; // see RL13
      intrusion_oe_o <= intr_pulse.active; // see RL3
      master_rst_oe_o <= rst_pulse.active; // see RL4
      power_sw_n_o <= !cfg[`HWM_CFG_PWR_ON]; // see RL5
      // one slow path through the register port, fan tach, chained irq and intrusion inputs, for board checks
      connectivity_test_out_o <= !(&{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, fan_tach_i,
        chained_mgmt_irq_in_n_i, intrusion_i}); // see RL8
    end
  end
endmodule
`default_nettype wire

// ### dv/hwm_board_model.sv
/*
  board around the pin logic: chassis tamper detector, pull-ups on the
  open-drain management interrupt and master reset lines. assumes the device shares the bench clock.
*/
`timescale 1ns/1ps
`default_nettype none
module hwm_board_model (
  // clock
  input wire logic core_clk_i,
  // chassis tamper event
  input wire logic tamper_i,
  // device pin drivers
  input wire logic intr_drv_i,
  input wire logic intr_oe_i,
  input wire logic mgmt_drv_i,
  input wire logic mgmt_oe_i,
  input wire logic rst_drv_i,
  input wire logic rst_oe_i,
  // resolved lines
  output logic intrusion_line_o,
  output logic mgmt_line_n_o,
  output logic rst_line_n_o
);
  logic tripped = 1'h0;
  // detector holds the line high until the device pulls it low
  always @(posedge core_clk_i) begin
    if (intr_oe_i)
      tripped <= 1'h0;
    else if (tamper_i)
      tripped <= 1'h1;
  end
  assign intrusion_line_o = intr_oe_i ? intr_drv_i : tripped;
  assign mgmt_line_n_o = mgmt_oe_i ? mgmt_drv_i : 1'h1;
  assign rst_line_n_o = rst_oe_i ? rst_drv_i : 1'h1;
endmodule
`default_nettype wire

// ### dv/hwm_pin_checker.sv
/*
  port assertions of the pin logic.
  assumes it is bound to hwm_pin_logic and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hwm_map.svh"
module hwm_pin_checker #(
  parameter int unsigned PULSE_CYCLES = 20,
  parameter int unsigned NFAN = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // pins
  input wire logic [NFAN-1:0] fan_tach_i,
  input wire logic chained_mgmt_irq_in_n_i,
  input wire logic mgmt_irq_out_o,
  input wire logic mgmt_irq_out_oe_o,
  input wire logic host_irq_o,
  input wire logic host_irq_oe_o,
  input wire logic intrusion_i,
  input wire logic intrusion_o,
  input wire logic intrusion_oe_o,
  input wire logic master_rst_n_o,
  input wire logic master_rst_oe_o,
  input wire logic power_sw_n_o,
  input wire logic connectivity_test_out_o
);
  logic up_q;
  logic [7:0] cfg_q;
  logic [7:0] mm2_q;
  int unsigned icnt;
  int unsigned rcnt;
  wire logic intr_go = reg_wr_i && reg_addr_i == `HWM_HMASK2 && reg_wdata_i[7];
  wire logic rst_go = reg_wr_i && reg_addr_i == `HWM_CFG && reg_wdata_i[7] && mm2_q[7];
  wire logic all_in = &{reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, fan_tach_i, chained_mgmt_irq_in_n_i, intrusion_i};
  // shadow gating registers so each output can be tied to its cause
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      up_q <= 1'h0;
      cfg_q <= 8'h00;
      mm2_q <= 8'hFF;
      icnt <= 0;
      rcnt <= 0;
    end else begin
      up_q <= 1'h1;
      icnt <= intrusion_oe_o ? icnt + 1 : 0;
      rcnt <= master_rst_oe_o ? rcnt + 1 : 0;
      if (reg_wr_i && reg_addr_i == `HWM_CFG)
        cfg_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `HWM_MMASK2)
        mm2_q <= reg_wdata_i;
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("read data not idle");
  open_drain_a: assert property (!intrusion_o && !master_rst_n_o && !mgmt_irq_out_o) else $error("bad drive");
  intr_len_a: assert property ($fell(intrusion_oe_o) |-> icnt == PULSE_CYCLES) else $error("clear length");
  rst_len_a: assert property ($fell(master_rst_oe_o) |-> rcnt == PULSE_CYCLES) else $error("reset length");
  intr_start_a: assert property ($rose(intrusion_oe_o) |-> $past(intr_go, 2)) else $error("clear cause");
  rst_start_a: assert property ($rose(master_rst_oe_o) |-> $past(rst_go, 2)) else $error("reset cause");
  chain_pass_a: assert property (up_q && !chained_mgmt_irq_in_n_i && cfg_q[1] && !mm2_q[6]
    |-> ##[1:2] mgmt_irq_out_oe_o) else $error("chain not passed");
  mgmt_gate_a: assert property (up_q && mgmt_irq_out_oe_o |-> $past(cfg_q[1])) else $error("mgmt gate");
  host_gate_a: assert property (up_q && host_irq_oe_o |-> $past(cfg_q[2])) else $error("host gate");
  host_mode_a: assert property (up_q |-> host_irq_o == $past(cfg_q[5])) else $error("host mode");
  power_ctl_a: assert property (up_q |-> power_sw_n_o == !$past(cfg_q[3])) else $error("power");
  test_nand_a: assert property (up_q |-> connectivity_test_out_o == !$past(all_in)) else $error("nand");
endmodule
bind hwm_pin_logic hwm_pin_checker #(.PULSE_CYCLES(PULSE_CYCLES), .NFAN(NFAN)) chk_u (.*);
`default_nettype wire

// ### dv/hwm_pin_logic_tb.sv
/*
  bench of the pin logic: register table rows, then pin scenarios.
  assumes the board model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
`include "hwm_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module hwm_pin_logic_tb;
  localparam int unsigned PC = 20;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} hwm_row_t;
  logic core_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, adc_data_i = 8'h00, reg_rdata_o;
  logic reg_wr_i = 1'h0, reg_rd_i = 1'h0, adc_valid_i = 1'h0, chained_mgmt_irq_in_n_i = 1'h1, tamper = 1'h0;
  logic [2:0] adc_chan_i = 3'h0, fan_tach_i = 3'h0;
  logic mgmt_irq_out_o, mgmt_irq_out_oe_o, host_irq_o, host_irq_oe_o, intrusion_i, intrusion_o, intrusion_oe_o;
  logic master_rst_n_o, master_rst_oe_o, power_sw_n_o, connectivity_test_out_o, mgmt_line_n, rst_line_n;
  int fail_count = 0;
  int checked = 0;
  hwm_row_t rows [21] = '{'{1'h0, 8'h40, 8'h00, 8'h00}, '{1'h0, 8'h43, 8'h00, 8'hFF}, '{1'h0, 8'h44, 8'h00, 8'hFF},
    '{1'h0, 8'h45, 8'h00, 8'hFF}, '{1'h0, 8'h46, 8'h00, 8'hFF}, '{1'h0, 8'h30, 8'h00, 8'hFF},
    '{1'h0, 8'h20, 8'h00, 8'h00}, '{1'h0, 8'h41, 8'h00, 8'h00}, '{1'h0, 8'hFF, 8'h00, 8'h00},
    '{1'h1, 8'hFF, 8'h5A, 8'h00}, '{1'h0, 8'hFF, 8'h00, 8'h00}, '{1'h1, 8'h40, 8'h2E, 8'h00},
    '{1'h0, 8'h40, 8'h00, 8'h2E}, '{1'h1, 8'h09, 8'h1F, 8'h00}, '{1'h1, 8'h08, 8'hA5, 8'h00},
    '{1'h1, 8'h08, 8'h3C, 8'h00}, '{1'h1, 8'h09, 8'h1F, 8'h00}, '{1'h0, 8'h08, 8'h00, 8'hA5},
    '{1'h0, 8'h08, 8'h00, 8'h3C}, '{1'h1, 8'h46, 8'hBF, 8'h00}, '{1'h0, 8'h46, 8'h00, 8'hBF}};
  always #12.5 core_clk_i = ~core_clk_i;
  hwm_pin_logic #(.PULSE_CYCLES(PC), .FAN_WINDOW(32)) dut_u (.*);
  hwm_board_model model_u (.core_clk_i(core_clk_i), .tamper_i(tamper), .intr_drv_i(intrusion_o),
    .intr_oe_i(intrusion_oe_o), .mgmt_drv_i(mgmt_irq_out_o), .mgmt_oe_i(mgmt_irq_out_oe_o),
    .rst_drv_i(master_rst_n_o), .rst_oe_i(master_rst_oe_o), .intrusion_line_o(intrusion_i),
    .mgmt_line_n_o(mgmt_line_n), .rst_line_n_o(rst_line_n));
  // one strobe cycle; read data is looked at only in the cycle after
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge core_clk_i);
    reg_wr_i <= w;
    reg_rd_i <= !w;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_wr_i <= 1'h0;
    reg_rd_i <= 1'h0;
    #1;
    if (!w) `CHK(reg_rdata_o, e)
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // run is about 190 cycles; a hang is cut well after that
  initial begin
    repeat (3000) @(posedge core_clk_i);
    fail_count++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'h1;
    foreach (rows[i]) bus(rows[i].w, rows[i].a, rows[i].d, rows[i].e);
    `CHK(power_sw_n_o, 1'h0)
    `CHK(host_irq_o, 1'h1)
    @(posedge core_clk_i) chained_mgmt_irq_in_n_i <= 1'h0;
    wait_n(3);
    `CHK(mgmt_line_n, 1'h0)
    bus(1'h0, `HWM_STAT2, 8'h00, 8'h40);
    bus(1'h1, `HWM_MMASK2, 8'hFF, 8'h00);
    wait_n(3);
    `CHK(mgmt_irq_out_oe_o, 1'h0)
    bus(1'h1, `HWM_MMASK2, 8'hBF, 8'h00);
    bus(1'h1, `HWM_CFG, 8'h2C, 8'h00);
    wait_n(3);
    `CHK(mgmt_irq_out_oe_o, 1'h0)
    @(posedge core_clk_i) chained_mgmt_irq_in_n_i <= 1'h1;
    bus(1'h1, `HWM_CFG, 8'h2E, 8'h00);
    bus(1'h1, `HWM_HMASK2, 8'h00, 8'h00);
    @(posedge core_clk_i) tamper <= 1'h1;
    @(posedge core_clk_i) tamper <= 1'h0;
    wait_n(3);
    bus(1'h0, `HWM_STAT2, 8'h00, 8'h10);
    `CHK(host_irq_oe_o, 1'h1)
    bus(1'h1, `HWM_HMASK2, 8'h80, 8'h00);
    wait_n(3);
    `CHK(intrusion_i, 1'h0)
    bus(1'h0, `HWM_STAT2, 8'h00, 8'h10);
    // a second start inside the pulse must not stretch it
    bus(1'h1, `HWM_HMASK2, 8'h80, 8'h00);
    wait_n(PC);
    // a stretched pulse would still drive the line here
    `CHK(intrusion_oe_o, 1'h0)
    bus(1'h0, `HWM_STAT2, 8'h00, 8'h00);
    `CHK(host_irq_oe_o, 1'h0)
    bus(1'h1, `HWM_CFG, 8'hAE, 8'h00);
    wait_n(3);
    `CHK(rst_line_n, 1'h0)
    wait_n(PC);
    `CHK(rst_line_n, 1'h1)
    bus(1'h1, `HWM_MMASK2, 8'h3F, 8'h00);
    bus(1'h1, `HWM_CFG, 8'hAE, 8'h00);
    wait_n(3);
    `CHK(master_rst_oe_o, 1'h0)
    @(posedge core_clk_i) begin
      adc_chan_i <= 3'h2;
      adc_data_i <= 8'h80;
      adc_valid_i <= 1'h1;
    end
    @(posedge core_clk_i) adc_valid_i <= 1'h0;
    bus(1'h0, 8'h22, 8'h00, 8'h80);
    bus(1'h1, 8'h32, 8'h7F, 8'h00);
    wait_n(2);
    bus(1'h0, `HWM_STAT1, 8'h00, 8'h04);
    bus(1'h0, `HWM_STAT1, 8'h00, 8'h04);
    @(posedge core_clk_i) nrst_i <= 1'h0;
    wait_n(2);
    `CHK(power_sw_n_o, 1'h1)
    `CHK(host_irq_o, 1'h0)
    @(posedge core_clk_i) nrst_i <= 1'h1;
    bus(1'h0, `HWM_CFG, 8'h00, 8'h00);
    // window restarts with reset, so five tach edges land before its first close
    repeat (5) begin
      @(posedge core_clk_i) fan_tach_i <= 3'h7;
      @(posedge core_clk_i) fan_tach_i <= 3'h0;
    end
    wait_n(22);
    bus(1'h0, 8'h27, 8'h00, 8'h05);
    bus(1'h0, 8'h29, 8'h00, 8'h05);
    tally_and_finish();
  end
endmodule
`default_nettype wire
